//--- verilog/lcd_cmd_pkg.sv
// Behaviour
// - on bit shows picture, off blanks panel
// - blanking leaves display ram untouched
// - start line instruction loads start register
// - panel shows consecutive lines from start line
// - set page selects page for later accesses
// - set y loads column counter directly
// - each data access increments y only
// - busy ignores all but status read
// - status on/off bit reads inverted control
// - reset bit high during init, status only
// - after init reset bit clears, all accepted
// - data write stores byte at page/y
// - data read returns byte at page/y
// - first read after address set is dummy
// - page field three bits under prefix 10111
// - y field six bits under prefix 01
// - start line field six bits, 0 to 63
// - on/off in bit 0, nothing else changes
package lcd_cmd_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CMD  = 12'h000; // write instruction, read status
	localparam logic [11:0] ADDR_DATA = 12'h004; // write/read display data

	// ----------------------------------------------------------------
	// status fields
	// ----------------------------------------------------------------
	localparam int STAT_BUSY_BIT  = 7;
	localparam int STAT_ONOFF_BIT = 5;
	localparam int STAT_RESET_BIT = 4;

	// ----------------------------------------------------------------
	// instruction encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_ONOFF  = 2'h0; // bits 7:6
	localparam logic [1:0] OP_SETY   = 2'h1; // bits 7:6
	localparam logic [1:0] OP_START  = 2'h3; // bits 7:6
	localparam logic [4:0] OP_PAGE   = 5'h17; // bits 7:3
	localparam int         ONOFF_BIT = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] START_RST = 6'h00;
	localparam logic [2:0] PAGE_RST  = 3'h0;
	localparam logic [5:0] Y_RST     = 6'h00;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int RESET_TIME_NS = 1000;
	localparam int BUSY_TIME_NS  = 4000;
	localparam int INIT_CYC      = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_CYC      = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// decoded instruction kinds
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		K_NONE, K_ONOFF, K_START, K_PAGE, K_SETY, K_WDATA
	} kind_e;

endpackage

//--- verilog/lcd_column_driver_cmd.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/100ps
module lcd_column_driver_cmd (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             display_on,
	output logic      [5:0]  start_line
);

	// ----------------------------------------------------------------
	// decode helper
	// ----------------------------------------------------------------
	// classify one queued entry: {data flag, byte}
	function automatic lcd_cmd_pkg::kind_e decode(input logic [8:0] e);
		lcd_cmd_pkg::kind_e k;
		k = lcd_cmd_pkg::K_NONE;
		if (e[8])
			k = lcd_cmd_pkg::K_WDATA;
		else if (e[7:3] == lcd_cmd_pkg::OP_PAGE)
			k = lcd_cmd_pkg::K_PAGE;
		else if (e[7:6] == lcd_cmd_pkg::OP_SETY)
			k = lcd_cmd_pkg::K_SETY;
		else if (e[7:6] == lcd_cmd_pkg::OP_START)
			k = lcd_cmd_pkg::K_START;
		else if (e[7:6] == lcd_cmd_pkg::OP_ONOFF)
			k = lcd_cmd_pkg::K_ONOFF;
		return k;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_BUSY} state_e;

	logic [7:0]  ram [0:511];         // display ram, page*64+y
	state_e      state_q, state_d;    // executor state
	logic [6:0]  cnt_q, cnt_d;        // init / busy countdown
	logic        on_q, on_d;          // display on flag
	logic [5:0]  start_q, start_d;    // start line register
	logic [2:0]  page_q, page_d;      // page register
	logic [5:0]  y_q, y_d;            // column counter
	logic [7:0]  out_q, out_d;        // read output register
	logic [8:0]  fifo_q [0:1];        // two-entry instruction buffer
	logic [8:0]  fifo_d [0:1];
	logic [1:0]  fcnt_q, fcnt_d;      // buffer fill
	logic [31:0] prdata_q, prdata_d;  // bus read data
	logic        pready_q, pready_d;  // bus ready
	logic        pslverr_q, pslverr_d;

	logic        access;              // access phase not yet answered
	logic        busy;                // instruction in progress
	logic        in_init;             // initialisation running
	logic        push, pop, rd_fire;  // buffer and read events
	logic        f_valid, f_ready;    // buffer handshake
	logic [8:0]  push_ent;            // entry to enqueue
	logic [8:0]  head;                // oldest entry
	logic [8:0]  ram_idx;             // page/y address
	logic [7:0]  status;              // status byte

	assign access   = psel && penable && !pready_q;
	assign in_init  = (state_q == ST_INIT);
	assign busy     = (state_q != ST_IDLE) || f_valid;
	assign f_valid  = (fcnt_q != 2'h0);
	assign f_ready  = (fcnt_q != 2'h2);
	assign head     = fifo_q[0];
	assign ram_idx  = {page_q, y_q};
	assign status   = {busy, 1'b0, !on_q, in_init, 4'h0};

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// answers one cycle into access; writes while busy are dropped
	always_comb begin
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		push      = 1'b0;
		push_ent  = {1'b0, pwdata[7:0]};
		rd_fire   = 1'b0;
		if (access) begin
			if (paddr == lcd_cmd_pkg::ADDR_CMD && !pwrite) begin
				pready_d = 1'b1;
				prdata_d = {24'h000000, status}; // status always readable
			end else if (paddr == lcd_cmd_pkg::ADDR_CMD || paddr == lcd_cmd_pkg::ADDR_DATA) begin
				push_ent = {paddr == lcd_cmd_pkg::ADDR_DATA, pwdata[7:0]};
				if (busy) begin
					// ignored while busy or initialising
					pready_d = 1'b1;
					prdata_d = 32'h00000000;
				end else if (pwrite) begin
					if (f_ready) begin
						pready_d = 1'b1;
						push     = 1'b1;
					end
				end else begin
					pready_d = 1'b1;
					rd_fire  = 1'b1;
					prdata_d = {24'h000000, out_q}; // last fetched byte
				end
			end else begin
				// unmapped address
				pready_d  = 1'b1;
				pslverr_d = 1'b1;
				prdata_d  = 32'h00000000;
			end
		end
	end

	// bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ----------------------------------------------------------------
	// instruction buffer
	// ----------------------------------------------------------------
	// shift-out buffer; executor drains only when idle
	always_comb begin
		fifo_d[0] = fifo_q[0];
		fifo_d[1] = fifo_q[1];
		fcnt_d    = fcnt_q;
		if (pop) begin
			fifo_d[0] = fifo_q[1];
			fcnt_d    = fcnt_q - 2'h1;
		end
		if (push) begin
			fifo_d[fcnt_d[0]] = push_ent;
			fcnt_d            = fcnt_d + 2'h1;
		end
	end

	// buffer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_q[0] <= 9'h000;
			fifo_q[1] <= 9'h000;
			fcnt_q    <= 2'h0;
		end else begin
			fifo_q[0] <= fifo_d[0];
			fifo_q[1] <= fifo_d[1];
			fcnt_q    <= fcnt_d;
		end
	end

	// ----------------------------------------------------------------
	// executor
	// ----------------------------------------------------------------
	assign pop = f_valid && (state_q == ST_IDLE);

	// one instruction at a time, then busy for a fixed time
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		on_d    = on_q;
		start_d = start_q;
		page_d  = page_q;
		y_d     = y_q;
		out_d   = out_q;
		case (state_q)
			ST_INIT: begin
				// init: display off, start line 0 held by reset
				if (cnt_q == 7'h00)
					state_d = ST_IDLE;
				else
					cnt_d = cnt_q - 7'h01;
			end
			ST_IDLE: begin
				if (pop) begin
					state_d = ST_BUSY;
					cnt_d   = 7'(lcd_cmd_pkg::BUSY_CYC - 1);
					case (decode(head))
						lcd_cmd_pkg::K_ONOFF: on_d = head[lcd_cmd_pkg::ONOFF_BIT];
						lcd_cmd_pkg::K_START: start_d = head[5:0];
						lcd_cmd_pkg::K_PAGE:  page_d = head[2:0];
						lcd_cmd_pkg::K_SETY:  y_d = head[5:0];
						lcd_cmd_pkg::K_WDATA: y_d = y_q + 6'h01; // wraps in page
						default: ;
					endcase
				end else if (rd_fire) begin
					// fetch next byte into output register, then advance
					state_d = ST_BUSY;
					cnt_d   = 7'(lcd_cmd_pkg::BUSY_CYC - 1);
					out_d   = ram[ram_idx];
					y_d     = y_q + 6'h01;
				end
			end
			ST_BUSY: begin
				if (cnt_q == 7'h00)
					state_d = ST_IDLE;
				else
					cnt_d = cnt_q - 7'h01;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// executor registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_INIT;
			cnt_q   <= 7'(lcd_cmd_pkg::INIT_CYC - 1);
			on_q    <= 1'b0;
			start_q <= lcd_cmd_pkg::START_RST;
			page_q  <= lcd_cmd_pkg::PAGE_RST;
			y_q     <= lcd_cmd_pkg::Y_RST;
			out_q   <= 8'h00;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			on_q    <= on_d;
			start_q <= start_d;
			page_q  <= page_d;
			y_q     <= y_d;
			out_q   <= out_d;
		end
	end

	// ----------------------------------------------------------------
	// display ram
	// ----------------------------------------------------------------
	// only data writes touch the array; on/off never does
	always_ff @(posedge pclk) begin
		if (pop && decode(head) == lcd_cmd_pkg::K_WDATA)
			ram[ram_idx] <= head[7:0];
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// panel refresh scans start_line onward for its row count
	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign display_on = on_q;
	assign start_line = start_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_ONOFF: assert property (@(posedge pclk) disable iff (!presetn)
		pop && decode(head) == lcd_cmd_pkg::K_ONOFF |=> display_on == $past(head[0]))
		else $error("display flag not loaded from bit 0");

	AST_START: assert property (@(posedge pclk) disable iff (!presetn)
		pop && decode(head) == lcd_cmd_pkg::K_START |=> start_line == $past(head[5:0]))
		else $error("start line not loaded");

	AST_PAGE: assert property (@(posedge pclk) disable iff (!presetn)
		!(pop && decode(head) == lcd_cmd_pkg::K_PAGE) |=> page_q == $past(page_q))
		else $error("page changed without set page");

	AST_SETY: assert property (@(posedge pclk) disable iff (!presetn)
		pop && decode(head) == lcd_cmd_pkg::K_SETY |=> y_q == $past(head[5:0]))
		else $error("column counter not loaded");

	AST_YINC: assert property (@(posedge pclk) disable iff (!presetn)
		(pop && decode(head) == lcd_cmd_pkg::K_WDATA) || rd_fire
		|=> y_q == $past(y_q) + 6'h01 && page_q == $past(page_q))
		else $error("column counter did not advance by one");

	AST_BUSY_IGNORE: assert property (@(posedge pclk) disable iff (!presetn)
		access && busy && paddr == lcd_cmd_pkg::ADDR_DATA
		|=> fcnt_q == $past(fcnt_q) - {1'b0, $past(pop)})
		else $error("access accepted while busy");

	AST_ONOFF_STAT: assert property (@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && paddr == lcd_cmd_pkg::ADDR_CMD && !pslverr
		|-> prdata[5] == !display_on)
		else $error("status on/off bit not inverted");

	AST_INIT: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> in_init [*8])
		else $error("initialisation ended too early");

	AST_INIT_END: assert property (@(posedge pclk) disable iff (!presetn)
		in_init && cnt_q == 7'h00 |=> !in_init ##0 state_q == ST_IDLE)
		else $error("initialisation did not finish");

	AST_BUSY_LEN: assert property (@(posedge pclk) disable iff (!presetn)
		pop |=> (state_q == ST_BUSY) [*8])
		else $error("busy period too short");

	AST_DUMMY: assert property (@(posedge pclk) disable iff (!presetn)
		rd_fire |=> out_q == $past(ram[ram_idx]))
		else $error("output register not refreshed");

endmodule

//--- tb/lcd_host_model.sv
`timescale 1ns/100ps
// apb host in the place of the microprocessor
module lcd_host_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready
);
	// ----------------------------------------
	// idle bus
	// ----------------------------------------
	// quiet bus at time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h00000000;
	end

	// ----------------------------------------
	// transfer
	// ----------------------------------------
	// one transfer, held until pready is sampled high
	task automatic xfer(
		input  logic        wr,
		input  logic [11:0] a,
		input  logic [31:0] d,
		output logic [31:0] q
	);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: only the bench watchdog ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep the last value
		paddr   <= ~a;
		pwdata  <= ~d;
		pwrite  <= ~wr;
	endtask
endmodule

//--- tb/lcd_column_driver_cmd_tb_top.sv
`timescale 1ns/100ps
module lcd_column_driver_cmd_tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        display_on;
	logic [5:0]  start_line;
	typedef struct {
		logic [31:0] exp;
		logic [31:0] mask;
		logic        err;
	} note_s;
	note_s       note_q[$]; // expected read results, oldest first
	int          error_cnt;
	int          cmp_count;
	logic [31:0] seed;      // xorshift state

	// clock of 50 ns
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	lcd_column_driver_cmd i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .display_on(display_on),
		.start_line(start_line)
	);

	lcd_host_model i_host (
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check_read(input note_s n, input logic [31:0] got, input logic gerr);
		cmp_count++;
		if (((got & n.mask) !== n.exp) || (gerr !== n.err)) begin
			error_cnt++;
			$display("CHECK FAILED read expected %h/%b seen %h/%b", n.exp, n.err, got, gerr);
		end
	endtask

	task automatic check_level(input string what, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	// read with its expected result noted first
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic er, output logic [31:0] q);
		note_q.push_back('{exp: e, mask: m, err: er});
		i_host.xfer(1'b0, a, 32'h00000000, q);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		i_host.xfer(1'b1, a, {24'h000000, d}, q);
	endtask

	// poll status until neither busy nor initialising
	task automatic wait_ready();
		logic [31:0] q;
		q = 32'h000000FF;
		// a flag that never clears is caught by the watchdog
		while (q[7] !== 1'b0 || q[4] !== 1'b0) begin
			rd(lcd_cmd_pkg::ADDR_CMD, 32'h00000000, 32'h00000000, 1'b0, q);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// monitor: completed reads against notes
	// ----------------------------------------
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			if (note_q.size() > 0) begin
				if (note_q[0].mask != 32'h00000000)
					check_read(note_q[0], prdata, pslverr);
				void'(note_q.pop_front());
			end
		end
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		give_verdict();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] q;
		logic [7:0]  d[3];
		logic [5:0]  s;
		logic [2:0]  p;
		error_cnt = 0;
		cmp_count = 0;
		seed = 32'h000083A6;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// init: busy, reset and off flags; instruction refused
		rd(lcd_cmd_pkg::ADDR_CMD, 32'h000000FF, 32'h000000B0, 1'b0, q);
		wr(lcd_cmd_pkg::ADDR_CMD, 8'h3F);
		wait_ready();
		rd(lcd_cmd_pkg::ADDR_CMD, 32'h000000FF, 32'h00000020, 1'b0, q);
		check_level("display_on", 8'h00, {7'h00, display_on});
		// start line; a second write while busy is dropped
		for (int i = 0; i < 3; i++) begin
			q = rnd();
			s = q[5:0];
			wr(lcd_cmd_pkg::ADDR_CMD, {2'h3, s});
			wr(lcd_cmd_pkg::ADDR_CMD, {2'h3, ~s});
			wait_ready();
			check_level("start_line", {2'h0, s}, {2'h0, start_line});
		end
		// three bytes at y 62 of a random page, wrapping to 0
		q = rnd();
		p = q[2:0];
		wr(lcd_cmd_pkg::ADDR_CMD, {5'h17, p});
		wait_ready();
		wr(lcd_cmd_pkg::ADDR_CMD, 8'h7E);
		wait_ready();
		for (int i = 0; i < 3; i++) begin
			q = rnd();
			d[i] = q[7:0];
			wr(lcd_cmd_pkg::ADDR_DATA, d[i]);
			wr(lcd_cmd_pkg::ADDR_DATA, ~d[i]);
			wait_ready();
		end
		// other page, same column
		wr(lcd_cmd_pkg::ADDR_CMD, {5'h17, ~p});
		wait_ready();
		wr(lcd_cmd_pkg::ADDR_CMD, 8'h7E);
		wait_ready();
		wr(lcd_cmd_pkg::ADDR_DATA, ~d[0]);
		wait_ready();
		// on then off, status shows inverse
		for (int i = 1; i >= 0; i--) begin
			wr(lcd_cmd_pkg::ADDR_CMD, 8'h3E | 8'(i));
			wait_ready();
			check_level("display_on", 8'(i), {7'h00, display_on});
			rd(lcd_cmd_pkg::ADDR_CMD, 32'h000000FF, (i == 1) ? 32'h0 : 32'h20, 1'b0, q);
		end
		// read back: one dummy, then the stored bytes
		wr(lcd_cmd_pkg::ADDR_CMD, {5'h17, p});
		wait_ready();
		wr(lcd_cmd_pkg::ADDR_CMD, 8'h7E);
		wait_ready();
		rd(lcd_cmd_pkg::ADDR_DATA, 32'h00000000, 32'h00000000, 1'b0, q);
		wait_ready();
		for (int i = 0; i < 3; i++) begin
			rd(lcd_cmd_pkg::ADDR_DATA, 32'hFFFFFFFF, {24'h0, d[i]}, 1'b0, q);
			rd(lcd_cmd_pkg::ADDR_DATA, 32'hFFFFFFFF, 32'h00000000, 1'b0, q);
			wait_ready();
		end
		// unmapped address
		rd(12'h008, 32'hFFFFFFFF, 32'h00000000, 1'b1, q);
		repeat (2) @(posedge pclk);
		give_verdict();
	end
endmodule
